// file: core/pwc_map.svh
// Constants of the wave counter: field positions, reset values, widths.
// Assumes inclusion by bare name from the design files.
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH

`define PWC_CNT_W        15
`define PWC_WORD_W       16
`define PWC_POL_BIT      15
`define PWC_CMP_MSB      14
`define PWC_TOP_RST      15'h03e8
`define PWC_PRESC_W      3
`define PWC_PRESC_RST    3'h0
`define PWC_LOAD_WAVE    2'h3
`define PWC_CHANNELS     4

`endif

// file: core/pwc_pkg.sv
// Types of the wave counter.
// Assumes nothing beyond the map header.
package pwc_pkg;
    typedef enum logic [1:0] {
        PWC_IDLE = 2'b00,
        PWC_UP   = 2'b01,
        PWC_DOWN = 2'b11
    } pwc_state_t;
endpackage

// file: core/pwc_tick_if.sv
// Prescaled tick and counter state shared between the modules.
// Assumes one clock domain.
interface pwc_tick_if;
    logic        tick;
    logic [14:0] count;
    logic [14:0] top;
    logic        run;
    modport src (output tick, count, top, run);
    modport snk (input tick, count, top, run);
endinterface

// file: core/pwc_prescaler.sv
// Divides the module clock by 2^sel into a one-cycle tick.
// Assumes a synchronous enable and a 25 MHz clock.
`include "pwc_map.svh"
module pwc_prescaler (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    // Control
    input  wire logic                      i_run,
    input  wire logic [`PWC_PRESC_W-1:0]   i_sel,
    // Tick
    output logic                           o_tick
);
    logic [7:0] div_reg;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_reg <= 8'h00;
        end else if (!i_run) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_comb begin
        o_tick = i_run && ((div_reg & ((8'h01 << i_sel) - 8'h01)) == 8'h00);
    end
endmodule // pwc_prescaler

// file: core/pwc_channel.sv
// One compare channel: holds word, drives its pin.
// Assumes the counter and tick come over the shared interface.
`include "pwc_map.svh"
module pwc_channel (
    // Clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rstn,
    // Counter state
    pwc_tick_if.snk                      cnt,
    // Word load from the sequence decoder
    input  wire logic                    i_load,
    input  wire logic [`PWC_WORD_W-1:0]  i_word,
    input  wire logic                    i_idle_level,
    // Pin
    output logic                         o_out
);
    logic [`PWC_CNT_W-1:0] cmp_reg;
    logic                  pol_reg;
    logic                  out_reg;
    logic                  active;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_reg <= 15'h0000;
            pol_reg <= 1'b0;
        end else if (i_load) begin
            cmp_reg <= i_word[`PWC_CMP_MSB:0]; // R6 R17
            pol_reg <= i_word[`PWC_POL_BIT];   // R7 R17
        end
    end

    // Falling polarity: high while count below compare; top<cmp stays high
    always_comb begin
        active = (cnt.count < cmp_reg) || (cnt.top < cmp_reg); // R5 R12
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_reg <= 1'b0;
        end else if (!cnt.run) begin
            out_reg <= i_idle_level; // R18
        end else begin
            out_reg <= pol_reg ? active : !active; // R2 R11 R15
        end
    end

    always_comb begin
        o_out = out_reg;
    end
endmodule // pwc_channel

// file: core/pwc_wave_counter.sv
// Wave counter of a four-channel pulse width unit.
// Assumes decoder strobes and control levels synchronous to i_core_clk.
//
// Behaviour
// R1: one 15-bit counter, four compare channels
// R2: shared period, own duty and polarity
// R3: direction setting selects up or up-down
// R4: period from top value and prescaler
// R5: top below compare: no edges, high
// R6: compare values only written by decoder
// R7: polarity from fetched word bit
// R8: top register writes never glitch period
// R9: load_mode_a load mode uses fetched top
// R10: other modes sample top at start/load
// R11: up mode wraps at top, outputs toggle
// R12: compare zero low, compare top high; up-down goes low for the tick at count top
// R13: up mode gives edge-aligned pulses
// R14: up period is top times tick
// R15: up-down counts back, centre-aligned pulses
// R16: up-down period twice top times tick
// R17: word: polarity bit 15, compare below
// R18: one step per tick, idle until start
`include "pwc_map.svh"
module pwc_wave_counter #(
    parameter int CHANNELS = `PWC_CHANNELS
) (
    // Clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_rstn,
    // Configuration
    input  wire logic                           i_count_up_then_down,
    input  wire logic [`PWC_PRESC_W-1:0]        i_prescale_sel,
    input  wire logic [1:0]                     i_load_mode,
    input  wire logic [`PWC_CNT_W-1:0]          i_period_top_value,
    input  wire logic [CHANNELS-1:0]            i_idle_level,
    // Sequence decoder
    input  wire logic                           i_sequence_start_task,
    input  wire logic                           i_stop_task,
    input  wire logic [CHANNELS-1:0]            i_load_channel,
    input  wire logic [CHANNELS*`PWC_WORD_W-1:0] i_load_word,
    input  wire logic                           i_load_top,
    input  wire logic [`PWC_CNT_W-1:0]          i_fetched_top,
    // Status
    output logic                                o_running,
    output logic                                o_period_end,
    output logic [`PWC_CNT_W-1:0]               o_count,
    // Pins
    output logic [CHANNELS-1:0]                 o_out
);
    pwc_tick_if tif ();

    pwc_pkg::pwc_state_t   state_reg;
    pwc_pkg::pwc_state_t   state_next;
    logic [`PWC_CNT_W-1:0] count_reg;
    logic [`PWC_CNT_W-1:0] count_next;
    logic [`PWC_CNT_W-1:0] top_reg;
    logic [`PWC_CNT_W-1:0] top_pend_reg;
    logic                  pend_reg;
    logic                  tick;
    logic                  wave_mode;
    logic                  period_end;
    logic                  pend_end_reg;
    logic                  up_last;

    // Load mode test used for both sampling paths
    function automatic logic is_wave(input logic [1:0] mode);
        return mode == `PWC_LOAD_WAVE;
    endfunction

    always_comb begin
        wave_mode = is_wave(i_load_mode);
    end

    pwc_prescaler u_presc (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_run      (state_reg != pwc_pkg::PWC_IDLE),
        .i_sel      (i_prescale_sel), // R4
        .o_tick     (tick)
    );

    // Up mode wraps one count early: top steps make one period
    always_comb begin
        up_last = (({1'b0, count_reg} + 16'h0001) >= {1'b0, top_reg});
    end

    // Period ends when the counter returns to zero
    always_comb begin
        period_end = 1'b0;
        if (tick) begin
            if (state_reg == pwc_pkg::PWC_UP && !i_count_up_then_down) begin
                period_end = up_last; // R14
            end else if (state_reg == pwc_pkg::PWC_DOWN) begin
                period_end = (count_reg <= 15'h0001); // R16
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            pwc_pkg::PWC_IDLE: begin
                count_next = 15'h0000; // R18
                if (i_sequence_start_task) begin
                    state_next = pwc_pkg::PWC_UP;
                end
            end
            pwc_pkg::PWC_UP: begin
                if (tick) begin
                    if (i_count_up_then_down && count_reg >= top_reg) begin
                        state_next = pwc_pkg::PWC_DOWN; // R3
                        count_next = count_reg - 15'h0001; // R15
                    end else if (!i_count_up_then_down && up_last) begin
                        count_next = 15'h0000; // R11 R13
                    end else begin
                        count_next = count_reg + 15'h0001; // R18
                    end
                end
            end
            pwc_pkg::PWC_DOWN: begin
                if (tick) begin
                    if (count_reg <= 15'h0001) begin
                        state_next = pwc_pkg::PWC_UP;
                        count_next = 15'h0000;
                    end else begin
                        count_next = count_reg - 15'h0001; // R16
                    end
                end
            end
            default: begin
                state_next = pwc_pkg::PWC_IDLE;
                count_next = 15'h0000;
            end
        endcase
        if (i_stop_task) begin
            state_next = pwc_pkg::PWC_IDLE;
            count_next = 15'h0000;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= pwc_pkg::PWC_IDLE;
            count_reg <= 15'h0000;
        end else begin
            state_reg <= state_next; // R1
            count_reg <= count_next;
        end
    end

    // Top value: staged, applied while idle or at a period boundary
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            top_pend_reg <= `PWC_TOP_RST;
            pend_reg     <= 1'b0;
        end else if (wave_mode && i_load_top) begin
            top_pend_reg <= i_fetched_top; // R9
            pend_reg     <= 1'b1;
        end else if (!wave_mode && (i_sequence_start_task || i_load_top)) begin
            top_pend_reg <= i_period_top_value; // R10
            pend_reg     <= 1'b1;
        end else if (period_end) begin
            pend_reg     <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            top_reg <= `PWC_TOP_RST;
        end else if (state_reg == pwc_pkg::PWC_IDLE && !wave_mode
                     && i_sequence_start_task) begin
            top_reg <= i_period_top_value; // R10
        end else if (state_reg == pwc_pkg::PWC_IDLE && pend_reg) begin
            top_reg <= top_pend_reg;
        end else if (period_end && pend_reg) begin
            top_reg <= top_pend_reg; // R8
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_end_reg <= 1'b0;
        end else begin
            pend_end_reg <= period_end;
        end
    end

    always_comb begin
        tif.tick  = tick;
        tif.count = count_reg;
        tif.top   = top_reg;
        tif.run   = (state_reg != pwc_pkg::PWC_IDLE);
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            pwc_channel u_ch (
                .i_core_clk   (i_core_clk),
                .i_rstn       (i_rstn),
                .cnt          (tif.snk),
                .i_load       (i_load_channel[g]), // R6
                .i_word       (i_load_word[g*`PWC_WORD_W +: `PWC_WORD_W]),
                .i_idle_level (i_idle_level[g]),
                .o_out        (o_out[g]) // R2
            );
        end
    endgenerate

    always_comb begin
        o_running    = tif.run;
        o_period_end = pend_end_reg;
        o_count      = count_reg;
    end
endmodule // pwc_wave_counter

// file: bench/pwc_wave_counter_sva.sv
// Checker of the wave counter: timing relations seen at the top ports.
// Assumes binding to the top module and one clock domain.
`include "pwc_map.svh"
module pwc_wave_counter_sva #(
    parameter int CHANNELS = `PWC_CHANNELS
) (
    input wire logic                    i_core_clk,
    input wire logic                    i_rstn,
    input wire logic                    i_count_up_then_down,
    input wire logic [`PWC_PRESC_W-1:0] i_prescale_sel,
    input wire logic [CHANNELS-1:0]     i_idle_level,
    input wire logic                    i_sequence_start_task,
    input wire logic                    i_stop_task,
    input wire logic                    o_running,
    input wire logic                    o_period_end,
    input wire logic [`PWC_CNT_W-1:0]   o_count,
    input wire logic [CHANNELS-1:0]     o_out
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    start_runs_a: assert property (i_sequence_start_task && !i_stop_task
        |=> o_running) else $error("start did not run");
    stop_idles_a: assert property (i_stop_task |=> !o_running)
        else $error("stop did not idle");
    fall_cause_a: assert property ($fell(o_running) |-> $past(i_stop_task))
        else $error("generation dropped without stop");
    idle_zero_a: assert property (!o_running ##1 !o_running
        |-> o_count == 15'h0) else $error("counter moved while idle");
    idle_pins_a: assert property (!o_running [*3]
        |-> o_out == $past(i_idle_level)) else $error("pins not idle");
    up_step_a: assert property (o_running && $past(o_running)
        && !i_count_up_then_down && $changed(o_count)
        |-> o_count == $past(o_count) + 15'h1 || o_count == 15'h0)
        else $error("bad up step");
    updown_step_a: assert property (o_running && $past(o_running)
        && i_count_up_then_down && $changed(o_count)
        |-> o_count == $past(o_count) + 15'h1
        || o_count == $past(o_count) - 15'h1) else $error("bad up-down step");
    tick_gap_a: assert property (o_running && i_prescale_sel != 3'h0
        && $changed(o_count) |=> $stable(o_count))
        else $error("step faster than tick");
    pend_pulse_a: assert property (o_period_end |=> !o_period_end)
        else $error("period end too long");
endmodule // pwc_wave_counter_sva

// file: bench/pwc_pin_loads.sv
// Loads on the pins: high time of each pin and length of each period.
// Assumes the period end pulse marks every period boundary.
module pwc_pin_loads (
    input  wire logic        i_core_clk,
    input  wire logic [3:0]  i_pin,
    input  wire logic        i_period_end,
    output logic      [15:0] o_high [4],
    output logic      [15:0] o_len
);
    logic [15:0] hi_reg [4];
    logic [15:0] len_reg;
    always @(posedge i_core_clk) begin
        for (int n = 0; n < 4; n++) begin
            hi_reg[n] <= (i_period_end ? 16'h0 : hi_reg[n]) + 16'(i_pin[n]);
            if (i_period_end) o_high[n] <= hi_reg[n];
        end
        len_reg <= i_period_end ? 16'h1 : len_reg + 16'h1;
        if (i_period_end) o_len <= len_reg;
    end
endmodule // pwc_pin_loads

// file: bench/pwc_wave_counter_test.sv
// Testbench of the wave counter: measures pins against expected duty.
// Assumes the core folder on the include path.
module pwc_wave_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, updown = 0, start = 0, stop = 0;
    logic        load_top = 0;
    logic [2:0]  presc = 0;
    logic [1:0]  lmode = 0;
    logic [14:0] sw_top = 0, f_top = 0, count;
    logic [3:0]  load_ch = 0, pins;
    logic [63:0] word = 0;
    logic        running, pend;
    logic [15:0] high [4];
    logic [15:0] len;
    logic [31:0] lfsr = 32'h3a03;
    int          num_errors = 0, checked = 0;
    pwc_wave_counter i_pwc_wave_counter (.i_core_clk(clk), .i_rstn(rstn),
        .i_count_up_then_down(updown), .i_prescale_sel(presc),
        .i_load_mode(lmode), .i_period_top_value(sw_top),
        .i_idle_level(4'h5), .i_sequence_start_task(start),
        .i_stop_task(stop), .i_load_channel(load_ch), .i_load_word(word),
        .i_load_top(load_top), .i_fetched_top(f_top), .o_running(running),
        .o_period_end(pend), .o_count(count), .o_out(pins));
    pwc_pin_loads i_pwc_pin_loads (.i_core_clk(clk), .i_pin(pins),
        .i_period_end(pend), .o_high(high), .o_len(len));
    always #20 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0d, expected %0d", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic periods(input int n);
        int t;
        t = 0;
        while (n > 0 && t < 5000) begin
            @(negedge clk);
            t++;
            if (pend === 1'b1) n--;
        end
        if (n > 0) check(32'h1, 32'h0);
    endtask
    task automatic run(input logic ud, input logic [2:0] sel, input int t,
                       input logic [1:0] lm);
        int div, per, c0;
        div = 1 << sel;
        lfsr = lfsr_next(lfsr);
        c0 = 1 + lfsr[7:0] % (t - 1);
        updown = ud;
        presc = sel;
        lmode = lm;
        f_top = 15'(t);
        sw_top = lm == 2'h3 ? 15'(t + 7) : 15'(t);
        load_ch = 4'hf;
        load_top = 1'b1;
        word = {1'b1, 15'(t + 1), 1'b1, 15'h0, 1'b0, 15'(c0), 1'b1, 15'(c0)};
        @(negedge clk);
        load_ch = 4'h0;
        load_top = 1'b0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        periods(3);
        per = (ud ? 2 : 1) * t * div;
        check(len, per);
        check(high[2], 0);
        check(high[3], per);
        if (!ud) begin
            check(high[0], c0 * div);
            check(high[1], per - c0 * div);
        end else begin
            check(high[0] + high[1], per);
            check(high[0], (2 * c0 - 1) * div);
        end
        stop = 1'b1;
        @(negedge clk);
        stop = 1'b0;
        @(negedge clk);
        $display("test ud=%0d sel=%0d top=%0d mode=%0d done", ud, sel, t, lm);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            run(i[0], {1'b0, i[2:1]}, 12 + lfsr[11:8], i[1] ? 2'h3 : 2'h0);
        end
        updown = 1'b0;
        presc = 3'h0;
        lmode = 2'h0;
        sw_top = 15'd16;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        periods(1);
        sw_top = 15'd28;
        periods(2);
        load_top = 1'b1;
        @(negedge clk);
        load_top = 1'b0;
        periods(3);
        check(len, 28);
        $display("test top reload done");
        finish_test();
    end
    initial begin
        #(40 * 40000);
        num_errors++;
        finish_test();
    end
endmodule // pwc_wave_counter_test
bind pwc_wave_counter pwc_wave_counter_sva #(.CHANNELS(CHANNELS))
    i_pwc_wave_counter_sva (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_count_up_then_down(i_count_up_then_down),
        .i_prescale_sel(i_prescale_sel), .i_idle_level(i_idle_level),
        .i_sequence_start_task(i_sequence_start_task),
        .i_stop_task(i_stop_task), .o_running(o_running),
        .o_period_end(o_period_end), .o_count(o_count), .o_out(o_out));
